// >>> core/slpc_defs.svh
`ifndef SLPC_DEFS_SVH
`define SLPC_DEFS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define SLPC_CTRL_ADDR      12'h000
`define SLPC_GATE_ADDR      12'h004
`define SLPC_STATUS_ADDR    12'h008

// ----------------------------------------
// control fields
// ----------------------------------------
`define SLPC_ARM_BIT        0
`define SLPC_MODE_LSB       1
`define SLPC_MODE_MSB       3
`define SLPC_CTRL_MASK      32'h0000000F
`define SLPC_CTRL_RESET     4'h0
`define SLPC_GATE_RESET     8'h00

// ----------------------------------------
// mode codes
// ----------------------------------------
`define SLPC_IDLE_CODE      3'h0
`define SLPC_POWER_DOWN_CODE_CODE     3'h2
`define SLPC_POWER_SAVE_CODE_CODE     3'h3
`define SLPC_STBY_CODE      3'h6
`define SLPC_XSTBY_CODE     3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define SLPC_HALT_CYCLES    3'h4
`define SLPC_OSC_START_NS   1000
`define SLPC_CLK_NS         10
`define SLPC_OSC_START_CYC  ((`SLPC_OSC_START_NS + `SLPC_CLK_NS - 1) / `SLPC_CLK_NS)

`endif

// >>> core/slpc_pkg.sv
package slpc_pkg;

  // controller states, gray along sleep -> wait osc -> halt -> run
  typedef enum logic [1:0] {
    SLPC_RUN   = 2'b00,
    SLPC_SLEEP = 2'b01,
    SLPC_OSC   = 2'b11,
    SLPC_HALT  = 2'b10
  } slpc_state_t;

  typedef logic [2:0] slpc_mode_t;

endpackage : slpc_pkg

// >>> core/slpc_counter.sv
`timescale 1ns/10ps

// ----------------------------------------
// down counter used for halt and startup
// ----------------------------------------
module slpc_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             ref_clk,  // system clock
  input  wire logic             reset,    // async reset, high
  input  wire logic             load,     // load start value
  input  wire logic [WIDTH-1:0] value,    // start value
  output logic                  done      // count at zero
);

  initial begin
    if (WIDTH < 2) begin
      $error("slpc_counter width too small");
    end
  end

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // count down to zero, reload wins
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = value;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done = (count == '0);

endmodule // slpc_counter

// >>> core/slpc_sleep_ctrl.sv
`timescale 1ns/10ps
`include "slpc_defs.svh"

// How it works
// - sleep only via sleep instruction from active
// - sleeping halts execution until wake or reset
// - enabled interrupts or reset wake the device
// - wake runs handler then next instruction
// - pending higher priority serviced first
// - cpu held four cycles after wake
// - registers and memory keep content asleep
// - reset during sleep does full restart
// - stopped clock source adds startup wait
// - idle stops cpu and nvm only
// - power-down stops every clock
// - power-down wakes on twi match, pins
// - power-save keeps enabled rtc running
// - standby keeps system clock sources
// - extended standby keeps sources and rtc
// - software gates single peripheral clocks
// - mode codes 000,010,011,110,111
// - sleep needs the arm bit set
module slpc_sleep_ctrl #(
  parameter int NUM_PERIPH    = 8,
  parameter int OSC_START_CYC = `SLPC_OSC_START_CYC
) (
  input  wire logic                  ref_clk,         // 100 MHz clock
  input  wire logic                  reset,           // async reset, high
  input  wire logic                  psel,            // apb select
  input  wire logic                  penable,         // apb enable
  input  wire logic                  pwrite,          // apb direction
  input  wire logic [11:0]           paddr,           // apb byte address
  input  wire logic [31:0]           pwdata,          // apb write data
  output logic      [31:0]           prdata,          // apb read data
  output logic                       pready,          // apb ready
  output logic                       pslverr,         // apb error
  input  wire logic                  sleep_instr,     // cpu executes sleep
  input  wire logic                  irq_any,         // any enabled interrupt
  input  wire logic                  irq_async_port,  // async pin interrupt
  input  wire logic                  irq_two_wire,    // two_wire_serial_port match
  input  wire logic                  irq_rtc,         // rtc overflow/compare
  input  wire logic                  rtc_enabled,     // rtc is enabled
  output logic                       cpu_run,         // cpu may execute
  output logic                       nvm_clk_en,      // nvm clock enable
  output logic                       cpu_clk_en,      // cpu clock enable
  output logic                       per_clk_en,      // peripheral clock enable
  output logic                       rtc_clk_en,      // rtc clock enable
  output logic                       sys_osc_en,      // system clock source on
  output logic                       rtc_osc_en,      // rtc clock source on
  output logic [NUM_PERIPH-1:0]      periph_clk_en    // per peripheral enable
);
  import slpc_pkg::*;

  initial begin
    if (NUM_PERIPH < 1 || NUM_PERIPH > 32) begin
      $error("NUM_PERIPH must be 1 to 32");
    end
    if (OSC_START_CYC < 1 || OSC_START_CYC > 65535) begin
      $error("OSC_START_CYC out of range");
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic mode_legal(input slpc_mode_t m);
    return m == `SLPC_IDLE_CODE || m == `SLPC_POWER_DOWN_CODE_CODE || m == `SLPC_POWER_SAVE_CODE_CODE ||
           m == `SLPC_STBY_CODE || m == `SLPC_XSTBY_CODE;
  endfunction

  // true when the mode keeps the system clock source running
  function automatic logic keeps_osc(input slpc_mode_t m);
    return m == `SLPC_IDLE_CODE || m == `SLPC_STBY_CODE || m == `SLPC_XSTBY_CODE;
  endfunction

  // true when the mode keeps the rtc domain running
  function automatic logic keeps_rtc(input slpc_mode_t m);
    return m == `SLPC_IDLE_CODE || m == `SLPC_POWER_SAVE_CODE_CODE || m == `SLPC_XSTBY_CODE;
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic                  sleep_arm_bit;
  slpc_mode_t            sleep_mode_select;
  logic [NUM_PERIPH-1:0] gate;
  logic                  next_arm;
  slpc_mode_t            next_mode;
  logic [NUM_PERIPH-1:0] next_gate;
  logic [31:0]           next_prdata;
  logic                  apb_setup;
  logic                  apb_access;
  logic                  addr_ok;

  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign pready     = 1'b1;
  assign addr_ok    = paddr == `SLPC_CTRL_ADDR || paddr == `SLPC_GATE_ADDR ||
                      paddr == `SLPC_STATUS_ADDR;

  slpc_state_t state;
  slpc_state_t next_state;
  slpc_mode_t  active_mode;
  slpc_mode_t  next_active_mode;
  logic        wake;

  // writes land on the access edge; read data is loaded on the setup edge so that
  // it already stands in the access cycle, while pready is high (zero wait states)
  always_comb begin
    next_arm    = sleep_arm_bit;
    next_mode   = sleep_mode_select;
    next_gate   = gate;
    next_prdata = prdata;
    if (apb_access && pwrite) begin
      if (paddr == `SLPC_CTRL_ADDR) begin
        next_arm  = pwdata[`SLPC_ARM_BIT];
        next_mode = pwdata[`SLPC_MODE_MSB:`SLPC_MODE_LSB];
      end else if (paddr == `SLPC_GATE_ADDR) begin
        next_gate = pwdata[NUM_PERIPH-1:0];
      end
    end
    if (apb_setup && !pwrite) begin
      next_prdata = 32'h00000000;
      if (paddr == `SLPC_CTRL_ADDR) begin
        next_prdata[3:0] = {sleep_mode_select, sleep_arm_bit};
      end else if (paddr == `SLPC_GATE_ADDR) begin
        next_prdata[NUM_PERIPH-1:0] = gate;
      end else if (paddr == `SLPC_STATUS_ADDR) begin
        next_prdata[1:0] = state;
        next_prdata[4:2] = active_mode;
        next_prdata[5]   = cpu_run;
      end
    end
  end

  // slverr mirrors the access cycle; a register that lags one cycle would miss it
  assign pslverr = apb_access && !addr_ok;

  // register contents are only touched by reset and bus accesses (prdata by reads), never by sleep
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sleep_arm_bit     <= 1'b0;
      sleep_mode_select <= 3'(`SLPC_CTRL_RESET >> 1);
      gate              <= '0;
      prdata            <= 32'h00000000;
    end else begin
      sleep_arm_bit     <= next_arm;
      sleep_mode_select <= next_mode;
      gate              <= next_gate;
      prdata            <= next_prdata;
    end
  end

  // ----------------------------------------
  // wake qualification by mode
  // ----------------------------------------
  always_comb begin
    wake = irq_async_port || irq_two_wire;
    if (active_mode == `SLPC_IDLE_CODE) begin
      wake = irq_any;
    end else if (keeps_rtc(active_mode)) begin
      wake = wake || (irq_rtc && rtc_enabled);
    end
  end

  // ----------------------------------------
  // sleep sequencer
  // ----------------------------------------
  logic osc_load;
  logic osc_done;
  logic halt_load;
  logic halt_done;

  always_comb begin
    next_state       = state;
    next_active_mode = active_mode;
    osc_load         = 1'b0;
    halt_load        = 1'b0;
    unique case (state)
      SLPC_RUN: begin
        // unarmed or reserved mode: instruction passes as a nop
        if (sleep_instr && sleep_arm_bit && mode_legal(sleep_mode_select)) begin
          next_state       = SLPC_SLEEP;
          next_active_mode = sleep_mode_select;
        end
      end
      SLPC_SLEEP: begin
        if (wake) begin
          if (keeps_osc(active_mode)) begin
            next_state = SLPC_HALT;
            halt_load  = 1'b1;
          end else begin
            next_state = SLPC_OSC;
            osc_load   = 1'b1;
          end
        end
      end
      SLPC_OSC: begin
        if (osc_done) begin
          next_state = SLPC_HALT;
          halt_load  = 1'b1;
        end
      end
      SLPC_HALT: begin
        if (halt_done) begin
          next_state = SLPC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state       <= SLPC_RUN;
      active_mode <= `SLPC_IDLE_CODE;
    end else begin
      state       <= next_state;
      active_mode <= next_active_mode;
    end
  end

  slpc_counter #(.WIDTH(16)) u_osc_cnt (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (osc_load),
    .value   (16'(OSC_START_CYC)),
    .done    (osc_done)
  );

  // loaded with three; the run state is reached four cycles after halt entry
  slpc_counter #(.WIDTH(3)) u_halt_cnt (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (halt_load),
    .value   (`SLPC_HALT_CYCLES - 3'h1),
    .done    (halt_done)
  );

  // ----------------------------------------
  // clock domain enables
  // ----------------------------------------
  logic asleep;
  assign asleep = state != SLPC_RUN;

  // interrupt order and return address are the cpu's: it simply resumes
  assign cpu_run    = !asleep;
  assign cpu_clk_en = !asleep;
  assign nvm_clk_en = !asleep;
  assign per_clk_en = !asleep || active_mode == `SLPC_IDLE_CODE;
  assign rtc_clk_en = !asleep || keeps_rtc(active_mode);
  assign rtc_osc_en = !asleep || keeps_rtc(active_mode);
  assign sys_osc_en = !asleep || keeps_osc(active_mode) || state == SLPC_OSC;
  assign periph_clk_en = per_clk_en ? ~gate : '0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  unarmed_nop_a : assert property (@(posedge ref_clk) disable iff (reset)
    (state == SLPC_RUN && sleep_instr && !sleep_arm_bit) |=> cpu_run)
    else $error("unarmed sleep stopped the cpu");

  enter_sleep_a : assert property (@(posedge ref_clk) disable iff (reset)
    (state == SLPC_RUN && sleep_instr && sleep_arm_bit && mode_legal(sleep_mode_select))
    |=> !cpu_run && !cpu_clk_en)
    else $error("armed sleep did not halt the cpu");

  halt_four_a : assert property (@(posedge ref_clk) disable iff (reset)
    $rose(state == SLPC_HALT) |-> !cpu_run [*4] ##1 cpu_run)
    else $error("post wake halt not four cycles");

  power_down_code_clocks_a : assert property (@(posedge ref_clk) disable iff (reset)
    (state == SLPC_SLEEP && active_mode == `SLPC_POWER_DOWN_CODE_CODE)
    |-> !per_clk_en && !rtc_clk_en && !sys_osc_en && !rtc_osc_en)
    else $error("clock running in power-down");

  power_down_code_wake_a : assert property (@(posedge ref_clk) disable iff (reset)
    (state == SLPC_SLEEP && active_mode == `SLPC_POWER_DOWN_CODE_CODE && !irq_async_port
     && !irq_two_wire) |=> state == SLPC_SLEEP)
    else $error("power-down woke on wrong source");

  power_save_code_rtc_a : assert property (@(posedge ref_clk) disable iff (reset)
    (state == SLPC_SLEEP && active_mode == `SLPC_POWER_SAVE_CODE_CODE) |-> rtc_clk_en && !sys_osc_en)
    else $error("power-save rtc domain wrong");

  stby_osc_a : assert property (@(posedge ref_clk) disable iff (reset)
    (state == SLPC_SLEEP && active_mode == `SLPC_STBY_CODE)
    |-> sys_osc_en && !rtc_clk_en && !per_clk_en)
    else $error("standby clocks wrong");

  xstby_a : assert property (@(posedge ref_clk) disable iff (reset)
    (state == SLPC_SLEEP && active_mode == `SLPC_XSTBY_CODE)
    |-> sys_osc_en && rtc_clk_en && !per_clk_en)
    else $error("extended standby clocks wrong");

  osc_wait_a : assert property (@(posedge ref_clk) disable iff (reset)
    (state == SLPC_SLEEP && wake && !keeps_osc(active_mode)) |=> state == SLPC_OSC)
    else $error("startup wait skipped");

  idle_wake_a : assert property (@(posedge ref_clk) disable iff (reset)
    (state == SLPC_SLEEP && active_mode == `SLPC_IDLE_CODE && irq_any)
    |=> state == SLPC_HALT)
    else $error("idle did not wake");

  gate_a : assert property (@(posedge ref_clk) disable iff (reset)
    !asleep |-> periph_clk_en == ~gate)
    else $error("peripheral gate mismatch");

endmodule // slpc_sleep_ctrl

// >>> sim/slpc_cpu_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// cpu core and interrupt controller model
// ----------------------------------------
module slpc_cpu_model (
  input  wire logic       ref_clk,        // system clock
  input  wire logic       reset,          // async reset, high
  input  wire logic       cpu_run,        // cpu may execute
  input  wire logic       do_sleep,       // bench asks for a sleep instruction
  input  wire logic [3:0] wake_sel,       // sources: other, async pin, two wire, rtc
  output logic            sleep_instr,    // sleep instruction executed
  output logic            irq_any,        // any enabled interrupt
  output logic            irq_async_port, // async pin interrupt
  output logic            irq_two_wire,   // two_wire_serial_port match
  output logic            irq_rtc         // rtc overflow or compare
);
  // a halted cpu executes nothing, so sleep only issues while running
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sleep_instr    <= 1'b0;
      irq_any        <= 1'b0;
      irq_async_port <= 1'b0;
      irq_two_wire   <= 1'b0;
      irq_rtc        <= 1'b0;
    end else begin
      sleep_instr    <= do_sleep & cpu_run;
      irq_any        <= |wake_sel;
      irq_async_port <= wake_sel[1];
      irq_two_wire   <= wake_sel[2];
      irq_rtc        <= wake_sel[3];
    end
  end
endmodule // slpc_cpu_model

// >>> sim/slpc_sleep_ctrl_bench.sv
`timescale 1ns/10ps
`include "slpc_defs.svh"

`define SLPC_CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h seen %0h", nm, ex, got); end end

module slpc_sleep_ctrl_bench;
  import slpc_pkg::*;
  localparam int OSC_CYC = 2;
  logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic        sleep_instr, irq_any, irq_async_port, irq_two_wire, irq_rtc, cpu_run;
  logic        nvm_clk_en, cpu_clk_en, per_clk_en, rtc_clk_en, sys_osc_en, rtc_osc_en;
  logic [7:0]  periph_clk_en, gate_val;
  logic        do_sleep, err, rtc_en;
  logic [3:0]  wake_sel;
  int          fail_count, cmp_count;
  wire logic [5:0] en_vec = {cpu_clk_en, nvm_clk_en, per_clk_en, rtc_clk_en, sys_osc_en,
                             rtc_osc_en};

  slpc_sleep_ctrl #(.NUM_PERIPH(8), .OSC_START_CYC(OSC_CYC)) dut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_instr(sleep_instr), .irq_any(irq_any), .irq_async_port(irq_async_port),
    .irq_two_wire(irq_two_wire), .irq_rtc(irq_rtc), .rtc_enabled(rtc_en),
    .cpu_run(cpu_run), .nvm_clk_en(nvm_clk_en), .cpu_clk_en(cpu_clk_en),
    .per_clk_en(per_clk_en), .rtc_clk_en(rtc_clk_en), .sys_osc_en(sys_osc_en),
    .rtc_osc_en(rtc_osc_en), .periph_clk_en(periph_clk_en));

  slpc_cpu_model cpu (
    .ref_clk(ref_clk), .reset(reset), .cpu_run(cpu_run), .do_sleep(do_sleep),
    .wake_sel(wake_sel), .sleep_instr(sleep_instr), .irq_any(irq_any),
    .irq_async_port(irq_async_port), .irq_two_wire(irq_two_wire), .irq_rtc(irq_rtc));

  // ----------------------------------------
  // clock and shared tasks
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // read data and error are taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin fail_count++; print_verdict(); end
    err    = pslverr;
    rd_val = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic sleep_now();
    @(posedge ref_clk) do_sleep <= 1'b1;
    @(posedge ref_clk) do_sleep <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    `SLPC_CHK("enables", 6'h3F, en_vec)
    `SLPC_CHK("run", 1'b1, cpu_run)
    apb(1'b0, `SLPC_CTRL_ADDR, 32'h0);
    `SLPC_CHK("ctrl", 32'h0, rd_val)
    gate_val = 8'hA5;
    apb(1'b1, `SLPC_GATE_ADDR, {24'h0, gate_val});
    @(posedge ref_clk) #1;
    `SLPC_CHK("gate", 8'h5A, periph_clk_en)
  endtask

  // unarmed sleep and reserved codes must leave the cpu running
  task automatic t_nop(input logic [3:0] ctrl);
    apb(1'b1, `SLPC_CTRL_ADDR, {28'h0, ctrl});
    sleep_now();
    `SLPC_CHK("nop run", 1'b1, cpu_run)
    `SLPC_CHK("nop en", 6'h3F, en_vec)
  endtask

  task automatic t_mode(input logic [2:0] code, input logic [5:0] ex_en,
                        input logic [3:0] bad, input logic [3:0] good, input int ex_cnt);
    int n;
    apb(1'b1, `SLPC_CTRL_ADDR, {28'h0, code, 1'b1});
    sleep_now();
    `SLPC_CHK("sleep run", 1'b0, cpu_run)
    `SLPC_CHK("sleep en", ex_en, en_vec)
    `SLPC_CHK("periph", ex_en[3] ? ~gate_val : 8'h00, periph_clk_en)
    apb(1'b0, `SLPC_STATUS_ADDR, 32'h0);
    `SLPC_CHK("status", {1'b0, code, 2'b01}, rd_val[5:0])
    if (bad != 4'h0) begin
      @(posedge ref_clk) wake_sel <= bad;
      repeat (10) @(posedge ref_clk);
      #1 `SLPC_CHK("no wake", 1'b0, cpu_run)
      @(posedge ref_clk) wake_sel <= 4'h0;
      repeat (2) @(posedge ref_clk);
    end
    @(posedge ref_clk) wake_sel <= good;
    @(posedge ref_clk) #1;
    for (n = 0; n < 200; n++) begin
      @(posedge ref_clk) #1;
      if (cpu_run === 1'b1) break;
    end
    if (n == 200) begin fail_count++; print_verdict(); end
    `SLPC_CHK("wake cycles", ex_cnt, n + 1)
    `SLPC_CHK("awake en", 6'h3F, en_vec)
    @(posedge ref_clk) wake_sel <= 4'h0;
    apb(1'b0, `SLPC_CTRL_ADDR, 32'h0);
    `SLPC_CHK("ctrl kept", {28'h0, code, 1'b1}, rd_val)
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    `SLPC_CHK("slverr", 1'b1, err)
    apb(1'b0, 12'h00C, 32'h0);
    `SLPC_CHK("unmapped rd", 32'h0, rd_val)
    apb(1'b0, `SLPC_GATE_ADDR, 32'h0);
    `SLPC_CHK("gate kept", {24'h0, gate_val}, rd_val)
    `SLPC_CHK("no slverr", 1'b0, err)
  endtask

  // with the rtc disabled its interrupt must not wake power-save
  task automatic t_rtc_off();
    @(posedge ref_clk) rtc_en <= 1'b0;
    t_mode(`SLPC_POWER_SAVE_CODE_CODE, 6'b000101, 4'h8, 4'h2, OSC_CYC + 6);
    @(posedge ref_clk) rtc_en <= 1'b1;
  endtask

  // a reset while asleep must restart everything from reset values
  task automatic t_reset_in_sleep();
    apb(1'b1, `SLPC_CTRL_ADDR, {28'h0, `SLPC_POWER_DOWN_CODE_CODE, 1'b1});
    sleep_now();
    @(posedge ref_clk) reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk) #1;
    `SLPC_CHK("rst run", 1'b1, cpu_run)
    `SLPC_CHK("rst periph", 8'hFF, periph_clk_en)
    apb(1'b0, `SLPC_CTRL_ADDR, 32'h0);
    `SLPC_CHK("rst ctrl", 32'h0, rd_val)
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; do_sleep = 1'b0; wake_sel = 4'h0; fail_count = 0; cmp_count = 0;
    rtc_en = 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk) #1;
    t_reset_values();
    t_nop({`SLPC_IDLE_CODE, 1'b0});
    t_nop(4'h3);
    t_nop(4'h9);
    t_nop(4'hB);
    t_mode(`SLPC_IDLE_CODE, 6'b001111, 4'h0, 4'h1, 5);
    t_mode(`SLPC_POWER_DOWN_CODE_CODE, 6'b000000, 4'h8, 4'h2, OSC_CYC + 6);
    t_mode(`SLPC_POWER_SAVE_CODE_CODE, 6'b000101, 4'h1, 4'h8, OSC_CYC + 6);
    t_mode(`SLPC_STBY_CODE, 6'b000010, 4'h8, 4'h4, 5);
    t_mode(`SLPC_XSTBY_CODE, 6'b000111, 4'h1, 4'h4, 5);
    t_rtc_off();
    t_unmapped();
    t_reset_in_sleep();
    print_verdict();
  end
endmodule // slpc_sleep_ctrl_bench
